// ==== logic/ddc_cfg.svh ====
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH
`define DDC_WORD_BITS    24
`define DDC_CNT_W        6
`define DDC_CMD_MSB      23
`define DDC_CMD_LSB      20
`define DDC_ADR_MSB      19
`define DDC_ADR_LSB      16
`define DDC_DAT_MSB      15
`define DDC_CMD_WRITE    4'h0
`define DDC_CMD_UPDATE   4'h1
`define DDC_CMD_WR_UPALL 4'h2
`define DDC_CMD_WR_UP    4'h3
`define DDC_CMD_PDOWN    4'h4
`define DDC_CMD_NOP      4'hf
`define DDC_ADR_A        4'h0
`define DDC_ADR_B        4'h1
`define DDC_ADR_ALL      4'hf
`define DDC_CODE_ZERO    16'h0000
`endif

// ==== logic/ddc_pkg.sv ====
package ddc_pkg;
  typedef struct packed {
    logic [3:0]  command_field;
    logic [3:0]  channel_select_field;
    logic [15:0] data;
  } ddc_word_t;

  typedef struct packed {
    logic [15:0] code;
    logic        enable;
  } ddc_chan_t;
endpackage : ddc_pkg

// ==== logic/ddc_top.sv ====
`timescale 1ns/1ps
`include "ddc_cfg.svh"

module ddc_top
  import ddc_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        sck_i,
  input  wire logic        sdi_i,
  input  wire logic        select_and_load_i,
  output logic [15:0]      analog_out_first_code_o,
  output logic             analog_out_first_en_o,
  output logic [15:0]      analog_out_second_code_o,
  output logic             analog_out_second_en_o
);

  // link domain: shift register on sck
  logic [23:0]             shift_q, shift_d;
  logic [5:0]              cnt_q, cnt_d;

  // level sample of select on sck; shift register holds while select high
  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    if (!select_and_load_i) begin
      shift_d = {shift_q[22:0], sdi_i};
      if (cnt_q != 6'(`DDC_WORD_BITS))
        cnt_d = cnt_q + 6'h01;
    end
  end

  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= 24'h00_0000;
    end else begin
      shift_q <= shift_d;
    end
  end

  // count cleared while select high, so short frames are seen
  always_ff @(posedge sck_i or posedge select_and_load_i) begin
    if (select_and_load_i) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // frame done toggle flipped at rising select when the count is 24
  logic                    done_q;
  logic [23:0]             word_q;
  always_ff @(posedge select_and_load_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
      word_q <= 24'h00_0000;
    end else begin
      done_q <= ~done_q ^ (cnt_q != 6'(`DDC_WORD_BITS));
      word_q <= shift_q;
    end
  end
  // toggle crosses into clock_i, three stages
  logic [2:0]              tog_q, tog_d;
  logic                    tog_seen_q, tog_seen_d;
  always_comb begin
    tog_d      = {tog_q[1:0], done_q};
    tog_seen_d = tog_q[2];
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_q      <= 3'h0;
      tog_seen_q <= 1'b0;
    end else begin
      tog_q      <= tog_d;
      tog_seen_q <= tog_seen_d;
    end
  end
  logic                    exec;
  assign exec = (tog_q[2] == tog_q[1]) && (tog_q[2] != tog_seen_q);

  // execute in core domain
  ddc_word_t               w;
  ddc_chan_t               in_q [2], in_d [2];
  ddc_chan_t               act_q [2], act_d [2];
  logic [1:0]              sel;
  assign w = ddc_word_t'(word_q);

  always_comb begin
    case (w.channel_select_field)
      `DDC_ADR_A:   sel = 2'b01;
      `DDC_ADR_B:   sel = 2'b10;
      `DDC_ADR_ALL: sel = 2'b11;
      default:      sel = 2'b00;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      in_d[i]  = in_q[i];
      act_d[i] = act_q[i];
      if (exec && sel[i]) begin
        case (w.command_field)
          `DDC_CMD_WRITE: begin
            in_d[i].code = w.data;
          end
          `DDC_CMD_UPDATE: begin
            act_d[i].code   = in_q[i].code;
            act_d[i].enable = 1'b1;
          end
          `DDC_CMD_WR_UP: begin
            in_d[i].code    = w.data;
            act_d[i].code   = w.data;
            act_d[i].enable = 1'b1;
          end
          `DDC_CMD_WR_UPALL: begin
            in_d[i].code = w.data;
          end
          `DDC_CMD_PDOWN: begin
            act_d[i].enable = 1'b0;
          end
          default: begin
          end
        endcase
      end
      if (exec && w.command_field == `DDC_CMD_WR_UPALL) begin
        act_d[i].code   = (sel[i]) ? w.data : in_q[i].code;
        act_d[i].enable = 1'b1;
      end
      in_d[i].enable = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 2; i++) begin
        in_q[i]  <= '{code: `DDC_CODE_ZERO, enable: 1'b0};
        act_q[i] <= '{code: `DDC_CODE_ZERO, enable: 1'b1};
      end
    end else begin
      in_q  <= in_d;
      act_q <= act_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_out_first_code_o  <= `DDC_CODE_ZERO;
      analog_out_first_en_o    <= 1'b1;
      analog_out_second_code_o <= `DDC_CODE_ZERO;
      analog_out_second_en_o   <= 1'b1;
    end else begin
      analog_out_first_code_o  <= act_q[0].code;
      analog_out_first_en_o    <= act_q[0].enable;
      analog_out_second_code_o <= act_q[1].code;
      analog_out_second_en_o   <= act_q[1].enable;
    end
  end

  // assertions
  property p_pdown_keeps;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_PDOWN && sel[0])
      |=> (!act_q[0].enable && $stable(act_q[0].code) && $stable(in_q[0].code));
  endproperty
  a_pdown_keeps: assert property (p_pdown_keeps) else $error("power down altered");

  property p_update;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_UPDATE && sel[0])
      |=> (act_q[0].code == $past(in_q[0].code) && act_q[0].enable);
  endproperty
  a_update: assert property (p_update) else $error("update wrong");

  property p_write_only;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_WRITE && sel[1])
      |=> (in_q[1].code == $past(w.data) && $stable(act_q[1].code));
  endproperty
  a_write_only: assert property (p_write_only) else $error("write wrong");

  property p_out_follows;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 analog_out_first_code_o == $past(act_q[0].code);
  endproperty
  a_out_follows: assert property (p_out_follows) else $error("output lag");

  property p_en_follows;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 analog_out_second_en_o == $past(act_q[1].enable);
  endproperty
  a_en_follows: assert property (p_en_follows) else $error("enable lag");

  property p_wrup;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_WR_UP && sel[1])
      |=> (act_q[1].code == in_q[1].code && act_q[1].enable);
  endproperty
  a_wrup: assert property (p_wrup) else $error("write update wrong");

  property p_upall;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_WR_UPALL)
      |=> (act_q[0].enable && act_q[1].enable);
  endproperty
  a_upall: assert property (p_upall) else $error("update all wrong");

  property p_nop;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_NOP) |=> ($stable(act_q[0]) && $stable(in_q[1]));
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");

  property p_upall_other;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_WR_UPALL && !sel[1])
      |=> (act_q[1].code == $past(in_q[1].code));
  endproperty
  a_upall_other: assert property (p_upall_other) else $error("update all copy wrong");

  property p_upall_addr;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_WR_UPALL && sel[0])
      |=> (act_q[0].code == $past(w.data) && in_q[0].code == $past(w.data));
  endproperty
  a_upall_addr: assert property (p_upall_addr) else $error("update all data wrong");

  property p_update_b;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_UPDATE && sel[1])
      |=> (act_q[1].code == $past(in_q[1].code) && act_q[1].enable);
  endproperty
  a_update_b: assert property (p_update_b) else $error("update b wrong");

  property p_update_keeps_in;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_UPDATE && sel[0])
      |=> $stable(in_q[0].code);
  endproperty
  a_update_keeps_in: assert property (p_update_keeps_in) else $error("update altered input");

  property p_pdown_b;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_PDOWN && sel[1])
      |=> (!act_q[1].enable && $stable(act_q[1].code) && $stable(in_q[1].code));
  endproperty
  a_pdown_b: assert property (p_pdown_b) else $error("power down b altered");

  property p_pdown_data;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_PDOWN)
      |=> ($stable(in_q[0].code) && $stable(in_q[1].code));
  endproperty
  a_pdown_data: assert property (p_pdown_data) else $error("power down used data");

  property p_write_a;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_WRITE && sel[0])
      |=> (in_q[0].code == $past(w.data) && $stable(act_q[0]));
  endproperty
  a_write_a: assert property (p_write_a) else $error("write a wrong");

  property p_wrup_a;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_WR_UP && sel[0])
      |=> (act_q[0].code == $past(w.data) && act_q[0].enable);
  endproperty
  a_wrup_a: assert property (p_wrup_a) else $error("write update a wrong");

  property p_wrup_in_b;
    @(posedge clock_i) disable iff (!rst_n_i)
      (exec && w.command_field == `DDC_CMD_WR_UP && sel[1])
      |=> (in_q[1].code == $past(w.data));
  endproperty
  a_wrup_in_b: assert property (p_wrup_in_b) else $error("write update input wrong");

  property p_idle_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      !exec |=> ($stable(act_q[0]) && $stable(act_q[1]));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state changed without frame");

  property p_exec_single;
    @(posedge clock_i) disable iff (!rst_n_i)
      exec |=> !exec;
  endproperty
  a_exec_single: assert property (p_exec_single) else $error("command executed twice");

  property p_out_second;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 analog_out_second_code_o == $past(act_q[1].code);
  endproperty
  a_out_second: assert property (p_out_second) else $error("output b lag");

  property p_en_first;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 analog_out_first_en_o == $past(act_q[0].enable);
  endproperty
  a_en_first: assert property (p_en_first) else $error("enable a lag");

  property p_cnt_sat;
    @(posedge sck_i) disable iff (select_and_load_i)
      cnt_q <= 6'(`DDC_WORD_BITS);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("bit count overrun");

  property p_shift_in;
    @(posedge sck_i) disable iff (!rst_n_i)
      !select_and_load_i |=> (shift_q[0] == $past(sdi_i));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit lost");

  property p_shift_msb;
    @(posedge sck_i) disable iff (!rst_n_i)
      !select_and_load_i |=> (shift_q[23:1] == $past(shift_q[22:0]));
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("shift order wrong");

endmodule : ddc_top

// ==== testbench/ddc_host_model.sv ====
`timescale 1ns/1ps
module ddc_host_model (
  output logic sck_o,
  output logic sdi_o,
  output logic select_and_load_o
);
  initial begin
    sck_o             = 1'h0;
    sdi_o             = 1'h0;
    select_and_load_o = 1'h1;
  end

  // msb first, 80 ns link clock only inside frames
  task automatic send(input logic [31:0] w, input int n);
    #7 select_and_load_o = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #40 sck_o = 1'h1;
      #40 sck_o = 1'h0;
    end
    #40 select_and_load_o = 1'h1;
    sdi_o = ~sdi_o;
  endtask : send
endmodule : ddc_host_model

// ==== testbench/tb_dual_dac_serial_command_port.sv ====
`timescale 1ns/1ps
module tb_dual_dac_serial_command_port;
  logic        clock_i;
  logic        rst_n_i;
  logic        sck;
  logic        sdi;
  logic        sel;
  logic [15:0] code_a;
  logic [15:0] code_b;
  logic        en_a;
  logic        en_b;
  int          n_fail = 0;
  int          samples_checked = 0;

  ddc_top ddc_top_i (
    .clock_i                  (clock_i),
    .rst_n_i                  (rst_n_i),
    .sck_i                    (sck),
    .sdi_i                    (sdi),
    .select_and_load_i        (sel),
    .analog_out_first_code_o  (code_a),
    .analog_out_first_en_o    (en_a),
    .analog_out_second_code_o (code_b),
    .analog_out_second_en_o   (en_b)
  );

  ddc_host_model ddc_host_model_i (
    .sck_o             (sck),
    .sdi_o             (sdi),
    .select_and_load_o (sel)
  );

  initial begin
    clock_i = 1'h0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic chk(input string nm, input logic [15:0] a, input logic ae,
                     input logic [15:0] b, input logic be);
    samples_checked++;
    if ({code_a, en_a, code_b, en_b} !== {a, ae, b, be}) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, {a, ae, b, be},
               {code_a, en_a, code_b, en_b});
    end
  endtask : chk

  // one frame, then idle past the answer latency
  task automatic frame(input logic [31:0] w, input int n);
    ddc_host_model_i.send(w, n);
    repeat (10) @(posedge clock_i);
  endtask : frame

  task automatic t_write_update;
    frame(32'h0000_1234, 24);
    chk("write only", 16'h0000, 1'h1, 16'h0000, 1'h1);
    frame(32'h0010_0000, 24);
    chk("update a", 16'h1234, 1'h1, 16'h0000, 1'h1);
    $display("test write_update done");
  endtask : t_write_update

  task automatic t_long_frame;
    frame(32'hff31_abcd, 32);
    chk("long write update b", 16'h1234, 1'h1, 16'habcd, 1'h1);
    $display("test long_frame done");
  endtask : t_long_frame

  task automatic t_power;
    frame(32'h004f_9999, 24);
    chk("power down all", 16'h1234, 1'h0, 16'habcd, 1'h0);
    frame(32'h0020_5555, 24);
    chk("write a update all", 16'h5555, 1'h1, 16'habcd, 1'h1);
    $display("test power done");
  endtask : t_power

  task automatic t_short_nop;
    frame(32'h00ff_0000, 24);
    chk("no operation", 16'h5555, 1'h1, 16'habcd, 1'h1);
    frame(32'h0030_7777, 23);
    chk("short frame", 16'h5555, 1'h1, 16'habcd, 1'h1);
    frame(32'h0001_0042, 24);
    chk("write b", 16'h5555, 1'h1, 16'habcd, 1'h1);
    frame(32'h0011_0000, 24);
    chk("update b", 16'h5555, 1'h1, 16'h0042, 1'h1);
    $display("test short_nop done");
  endtask : t_short_nop

  task automatic print_verdict;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #1000000;
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_n_i = 1'h0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    chk("after reset", 16'h0000, 1'h1, 16'h0000, 1'h1);
    t_write_update();
    t_long_frame();
    t_power();
    t_short_nop();
    print_verdict();
  end
endmodule : tb_dual_dac_serial_command_port
